// ---- rtl/updown_timer_pkg.sv ----
/*
 * package for the 8-bit up/down reload timer: register offsets, field positions,
 * reset values, clock select codes and prescaler tap ratios.
 * assumes a byte-wide register port with one-cycle strobes.
 */
package updown_timer_pkg;

	// register offsets on the plain register port
	localparam logic [2:0] ADDR_MODE   = 3'h0; // timer_mode_ctrl
	localparam logic [2:0] ADDR_COUNT  = 3'h1; // count_value read, reload_value write
	localparam logic [2:0] ADDR_EDGE   = 3'h2; // edge_select_reg
	localparam logic [2:0] ADDR_IRQREQ = 3'h3; // interrupt_request_reg_two
	localparam logic [2:0] ADDR_IRQEN  = 3'h4; // interrupt_enable_reg_two

	// mode register fields
	localparam int BIT_RELOAD_SEL = 7;
	localparam int BIT_DIR_HW     = 6;
	localparam int BIT_DIR_SW     = 5;
	localparam int CLK_SEL_MSB    = 2;
	localparam int CLK_SEL_LSB    = 0;
	localparam logic [7:0] MODE_RESET     = 8'h18;
	localparam logic [7:0] MODE_FIXED_ONE = 8'h18; // bits 4 and 3
	localparam logic [7:0] MODE_WR_MASK   = 8'hE7;

	// other register fields
	localparam int BIT_EVENT_EDGE = 0; // 1 = rising edge counts
	localparam int BIT_OVF_FLAG   = 0;
	localparam int BIT_OVF_EN     = 0;

	localparam logic [7:0] COUNT_RESET  = 8'h00;
	localparam logic [7:0] RELOAD_RESET = 8'h00;
	localparam logic [7:0] COUNT_MAX    = 8'hFF;
	localparam logic [7:0] COUNT_MIN    = 8'h00;
	localparam logic [7:0] READ_ZERO    = 8'h00;

	// clock select codes
	localparam logic [2:0] CS_DIV8192 = 3'h0;
	localparam logic [2:0] CS_DIV2048 = 3'h1;
	localparam logic [2:0] CS_DIV512  = 3'h2;
	localparam logic [2:0] CS_DIV64   = 3'h3;
	localparam logic [2:0] CS_DIV16   = 3'h4;
	localparam logic [2:0] CS_DIV4    = 3'h5;
	localparam logic [2:0] CS_SUB4    = 3'h6;
	localparam logic [2:0] CS_EVENT   = 3'h7;

	// prescaler tap bit: divide by 2^(bit+1) gives one pulse per period
	localparam int PRESCALE_WIDTH = 13;
	localparam int TAP_8192 = 12;
	localparam int TAP_2048 = 10;
	localparam int TAP_512  = 8;
	localparam int TAP_64   = 5;
	localparam int TAP_16   = 3;
	localparam int TAP_4    = 1;
	localparam int SUB_DIV  = 4;

	// register port request
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [2:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// synchronised pin levels
	typedef struct packed {
		logic event_lvl;
		logic dir_lvl;
	} pin_sync_t;

endpackage

// ---- rtl/pin_sync3.sv ----
/*
 * three-stage synchroniser with agreement filter for the timer's input pins.
 * assumes asynchronous pins and one system clock.
 */
`timescale 1ns/10ps
module pin_sync3 #(
	parameter int WIDTH = 2
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] pinIn,
	output logic      [WIDTH-1:0] pinLevel
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// stage1 feeds only stage2; a change is taken once stage2 and stage3 agree
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stage1   <= '0;
			stage2   <= '0;
			stage3   <= '0;
			pinLevel <= '0;
		end else begin
			stage1 <= pinIn;
			stage2 <= stage1;
			stage3 <= stage2;
			for (int i = 0; i < WIDTH; i++) begin
				if (stage2[i] == stage3[i]) begin
					pinLevel[i] <= stage3[i];
				end
			end
		end
	end
endmodule // pin_sync3

// ---- rtl/updown_reload_timer8.sv ----
/*
 * 8-bit up/down timer with interval and auto-reload modes, prescaler taps,
 * sub-clock tap, external event counting and an overflow interrupt.
 * assumes a cpu on a plain byte register port and a free-running sub-clock
 * tick supplied as a one-cycle enable on the system clock.
 */
`timescale 1ns/10ps
module updown_reload_timer8
	import updown_timer_pkg::*;
#(
	parameter int COUNT_WIDTH = 8
) (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire logic [2:0]             regAddr,
	input  wire logic [7:0]             regWdata,
	input  wire logic                   regWr,
	input  wire logic                   regRd,
	output logic      [7:0]             regRdata,
	input  wire logic                   subClkTick,
	input  wire logic                   eventInputPin,
	input  wire logic                   directionPin,
	output logic                        irq,
	output logic                        countTick
);
	reg_req_t               req;
	pin_sync_t              pins;
	logic [7:0]             modeReg;
	logic [COUNT_WIDTH-1:0] countValue;
	logic [COUNT_WIDTH-1:0] reloadValue;
	logic                   eventEdgeSelectBit;
	logic                   overflowRequestFlag;
	logic                   overflowIrqEnableBit;
	logic [PRESCALE_WIDTH-1:0] prescale;
	logic [PRESCALE_WIDTH-1:0] prescalePrev;
	logic [1:0]             subCount;
	logic                   subTick;
	logic                   eventPrev;
	logic                   countStep;
	logic                   countDown;
	logic                   wrap;
	logic [2:0]             clockSelectField;
	logic [COUNT_WIDTH-1:0] next_count;

	assign req = '{wr: regWr, rd: regRd, addr: regAddr, wdata: regWdata};
	assign clockSelectField = modeReg[CLK_SEL_MSB:CLK_SEL_LSB];

	// both pins pass the three-stage filter before any logic sees them
	pin_sync3 #(
		.WIDTH (2)
	) u_sync (
		.clk      (clk),
		.rst_n    (rst_n),
		.pinIn    ({eventInputPin, directionPin}),
		.pinLevel (pins)
	);

	// free-running prescaler; a tap ticks when its bit falls
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prescale     <= '0;
			prescalePrev <= '0;
		end else begin
			prescale     <= prescale + 1'b1;
			prescalePrev <= prescale;
		end
	end

	// sub-clock divided by four; the tick is already on the system clock
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			subCount <= '0;
			subTick  <= 1'b0;
		end else begin
			subTick <= 1'b0;
			if (subClkTick) begin
				subCount <= subCount + 1'b1;
				subTick  <= (subCount == 2'(SUB_DIV - 1));
			end
		end
	end

	// event pin edge memory, taken from the filtered level only
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			eventPrev <= 1'b0;
		end else begin
			eventPrev <= pins.event_lvl;
		end
	end

	// pick the count clock; a falling tap bit happens once per divider period
	always_comb begin
		countStep = 1'b0;
		unique case (clockSelectField)
			CS_DIV8192: countStep = prescalePrev[TAP_8192] & ~prescale[TAP_8192];
			CS_DIV2048: countStep = prescalePrev[TAP_2048] & ~prescale[TAP_2048];
			CS_DIV512:  countStep = prescalePrev[TAP_512] & ~prescale[TAP_512];
			CS_DIV64:   countStep = prescalePrev[TAP_64] & ~prescale[TAP_64];
			CS_DIV16:   countStep = prescalePrev[TAP_16] & ~prescale[TAP_16];
			CS_DIV4:    countStep = prescalePrev[TAP_4] & ~prescale[TAP_4];
			CS_SUB4:    countStep = subTick;
			CS_EVENT: begin
				// one step per qualifying edge of the filtered pin
				if (eventEdgeSelectBit) begin
					countStep = pins.event_lvl & ~eventPrev;
				end else begin
					countStep = ~pins.event_lvl & eventPrev;
				end
			end
		endcase
	end

	// direction: pin wins when hardware control is on, high means down
	always_comb begin
		if (modeReg[BIT_DIR_HW]) begin
			countDown = pins.dir_lvl;
		end else begin
			countDown = modeReg[BIT_DIR_SW];
		end
	end

	// wrap detection and next count value
	always_comb begin
		wrap = countDown ? (countValue == COUNT_MIN) : (countValue == COUNT_MAX);
		if (wrap && modeReg[BIT_RELOAD_SEL]) begin
			next_count = reloadValue;
		end else if (countDown) begin
			next_count = countValue - 1'b1;
		end else begin
			next_count = countValue + 1'b1;
		end
	end

	// mode register; bits 4 and 3 are not storage
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			modeReg <= MODE_RESET;
		end else if (req.wr && req.addr == ADDR_MODE) begin
			modeReg <= (req.wdata & MODE_WR_MASK) | MODE_FIXED_ONE;
		end
	end

	// reload register, write-only, shares the counter address
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reloadValue <= RELOAD_RESET;
		end else if (req.wr && req.addr == ADDR_COUNT) begin
			reloadValue <= req.wdata;
		end
	end

	// counter: a reload write beats a step in the same cycle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			countValue <= COUNT_RESET;
		end else if (req.wr && req.addr == ADDR_COUNT) begin
			countValue <= req.wdata;
		end else if (countStep) begin
			countValue <= next_count;
		end
	end

	// step strobe out, registered, so it rises at the same edge the counter moves
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			countTick <= 1'b0;
		end else begin
			countTick <= countStep & ~(req.wr && req.addr == ADDR_COUNT);
		end
	end

	// edge select and interrupt enable registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			eventEdgeSelectBit   <= 1'b0;
			overflowIrqEnableBit <= 1'b0;
		end else if (req.wr) begin
			if (req.addr == ADDR_EDGE) begin
				eventEdgeSelectBit <= req.wdata[BIT_EVENT_EDGE];
			end
			if (req.addr == ADDR_IRQEN) begin
				overflowIrqEnableBit <= req.wdata[BIT_OVF_EN];
			end
		end
	end

	// sticky overflow flag; a wrap in the clearing cycle wins over the clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			overflowRequestFlag <= 1'b0;
		end else if (countStep && wrap && !(req.wr && req.addr == ADDR_COUNT)) begin
			overflowRequestFlag <= 1'b1;
		end else if (req.wr && req.addr == ADDR_IRQREQ && !req.wdata[BIT_OVF_FLAG]) begin
			overflowRequestFlag <= 1'b0;
		end
	end

	// level interrupt, registered so the pin comes from a flip-flop
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= overflowRequestFlag & overflowIrqEnableBit;
		end
	end

	// read data one cycle after the strobe, zero otherwise; reads change nothing
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			regRdata <= READ_ZERO;
		end else if (req.rd) begin
			unique case (req.addr)
				ADDR_MODE:   regRdata <= modeReg | MODE_FIXED_ONE;
				ADDR_COUNT:  regRdata <= countValue;
				ADDR_EDGE:   regRdata <= {7'h00, eventEdgeSelectBit};
				ADDR_IRQREQ: regRdata <= {7'h00, overflowRequestFlag};
				ADDR_IRQEN:  regRdata <= {7'h00, overflowIrqEnableBit};
				default:     regRdata <= READ_ZERO;
			endcase
		end else begin
			regRdata <= READ_ZERO;
		end
	end
endmodule // updown_reload_timer8

// ---- tb/timer_checker_assertions.sv ----
/*
 checker for the timer's register port, tick and interrupt outputs.
 assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/10ps
module timer_checker
	import updown_timer_pkg::*;
#(
	parameter int COUNT_WIDTH = 8
) (
	input wire logic       clk,
	input wire logic       rst_n,
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic       regWr,
	input wire logic       regRd,
	input wire logic [7:0] regRdata,
	input wire logic       subClkTick,
	input wire logic       eventInputPin,
	input wire logic       directionPin,
	input wire logic       irq,
	input wire logic       countTick
);
	// everything here lives on the system clock
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// read data may only show in the slot after a read strobe
	rdata_idle_a: assert property (!$past(regRd) |-> regRdata == 8'h00)
		else $error("read data not zero outside read slot");
	unmapped_a: assert property ($past(regRd) && $past(regAddr) > ADDR_IRQEN
		|-> regRdata == READ_ZERO)
		else $error("unmapped read not zero");
	mode_fixed_a: assert property ($past(regRd) && $past(regAddr) == ADDR_MODE
		|-> regRdata[4:3] == 2'b11)
		else $error("mode fixed bits not one");
	mode_rw_a: assert property (regWr && regAddr == ADDR_MODE ##1 regRd && regAddr == ADDR_MODE
		|=> regRdata == (($past(regWdata, 2) & MODE_WR_MASK) | MODE_FIXED_ONE))
		else $error("mode readback wrong");
	count_load_a: assert property (regWr && regAddr == ADDR_COUNT ##1 regRd
		&& regAddr == ADDR_COUNT |=> regRdata == $past(regWdata, 2))
		else $error("counter not loaded by reload write");
	tick_pulse_a: assert property (countTick |=> !countTick)
		else $error("count tick longer than one cycle");
	// irq moves only after a wrapping step or a register write
	irq_rise_a: assert property ($rose(irq) |-> $past(countTick) || $past(regWr, 2))
		else $error("irq rose without cause");
	irq_fall_a: assert property ($fell(irq) |-> $past(regWr, 2))
		else $error("irq fell without a write");
endmodule // timer_checker

bind updown_reload_timer8 timer_checker #(.COUNT_WIDTH(COUNT_WIDTH)) u_timer_checker (.clk,
	.rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .subClkTick, .eventInputPin,
	.directionPin, .irq, .countTick);

// ---- tb/cpu_bus_model.sv ----
/*
 cpu side of the timer's register port: single-byte writes and reads.
 assumes every task is entered just after a rising clock edge.
*/
`timescale 1ns/10ps
module cpu_bus_model (
	input  wire logic       clk,
	input  wire logic [7:0] regRdata,
	output logic      [2:0] regAddr  = 3'h7,
	output logic      [7:0] regWdata = 8'h00,
	output logic            regWr    = 1'b0,
	output logic            regRd    = 1'b0
);
	// one-cycle strobe; the trailing delay keeps back-to-back calls off one time step
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
		#1;
	endtask

	// data stand only in the cycle after the strobe, so take them there
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask
endmodule // cpu_bus_model

// ---- tb/updown_reload_timer8_tb.sv ----
/*
 self-checking bench for the 8-bit up/down reload timer.
 assumes the cpu model on the register port; pins are driven here.
*/
`timescale 1ns/10ps
module updown_reload_timer8_tb import updown_timer_pkg::*;;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       subClkTick = 1'b0;
	logic       eventInputPin = 1'b0;
	logic       directionPin = 1'b0;
	logic [2:0] regAddr;
	logic [7:0] regWdata, regRdata, rv;
	logic       regWr, regRd, irq, countTick;
	int         n_errors = 0;
	int         tests_run = 0;
	int         n;

	// system clock and a sub-clock tick every other cycle
	initial forever #10 clk = ~clk;
	always @(posedge clk) subClkTick <= ~subClkTick;

	updown_reload_timer8 u_updown_reload_timer8 (.clk, .rst_n, .regAddr, .regWdata, .regWr,
		.regRd, .regRdata, .subClkTick, .eventInputPin, .directionPin, .irq, .countTick);
	cpu_bus_model u_cpu_bus_model (.clk, .regRdata, .regAddr, .regWdata, .regWr, .regRd);

	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(logic [2:0] a, logic [7:0] d);
		u_cpu_bus_model.wr(a, d);
	endtask
	task automatic rdc(string nm, logic [2:0] a, logic [7:0] e);
		u_cpu_bus_model.rd(a, rv);
		chk(nm, {8'h00, e}, {8'h00, rv});
	endtask
	// cycles up to the next counter step, bounded by the slowest tap
	task automatic tick(output int c);
		c = 0;
		do begin
			@(posedge clk);
			#1 c++;
		end while (countTick !== 1'b1 && c < 9000);
		if (c >= 9000) chk("tick wait", 16'h0000, 16'h0001);
	endtask
	task automatic finish_test;
		$display("checks %0d errors %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	task automatic t_regs;
		rdc("mode", ADDR_MODE, MODE_RESET);
		rdc("count", ADDR_COUNT, COUNT_RESET);
		rdc("unmapped", 3'h7, READ_ZERO);
		wr(ADDR_MODE, 8'hE7);
		rdc("mode all", ADDR_MODE, 8'hFF);
		wr(ADDR_MODE, 8'h00);
		rdc("mode none", ADDR_MODE, 8'h18);
	endtask
	// spacing of two steps for clock select codes 0 to 6; sub-clock tick comes every 2 cycles
	task automatic t_taps;
		int dv[7] = '{8192, 2048, 512, 64, 16, 4, 8};
		for (int i = 0; i < 7; i++) begin
			wr(ADDR_MODE, 8'(i));
			tick(n);
			tick(n);
			chk("tap spacing", 16'(dv[i]), 16'(n));
		end
	endtask
	task automatic t_interval;
		wr(ADDR_COUNT, 8'h80);
		wr(ADDR_IRQREQ, 8'h00);
		wr(ADDR_IRQEN, 8'h01);
		wr(ADDR_MODE, 8'h05);
		wr(ADDR_COUNT, 8'hFE);
		rdc("load", ADDR_COUNT, 8'hFE);
		tick(n);
		tick(n);
		rdc("wrap", ADDR_COUNT, 8'h00);
		rdc("flag", ADDR_IRQREQ, 8'h01);
		chk("irq", 16'h0001, {15'h0, irq});
		wr(ADDR_IRQREQ, 8'h00);
		rdc("flag clear", ADDR_IRQREQ, 8'h00);
		chk("irq clear", 16'h0000, {15'h0, irq});
	endtask
	// reload, down, masked: 02 01 00 then underflow back to 02
	task automatic t_reload;
		wr(ADDR_IRQEN, 8'h00);
		wr(ADDR_MODE, 8'hA5);
		wr(ADDR_IRQREQ, 8'h00);
		// load last: a step in the load cycle is dropped, so no tick is missed
		wr(ADDR_COUNT, 8'h02);
		repeat (3) tick(n);
		rdc("reload", ADDR_COUNT, 8'h02);
		rdc("uflow flag", ADDR_IRQREQ, 8'h01);
		chk("masked irq", 16'h0000, {15'h0, irq});
	endtask
	// software bit says down, pin decides
	task automatic t_pin;
		wr(ADDR_MODE, 8'h65);
		wr(ADDR_COUNT, 8'h10);
		tick(n);
		rdc("pin up", ADDR_COUNT, 8'h11);
		directionPin <= 1'b1;
		repeat (6) @(posedge clk);
		wr(ADDR_COUNT, 8'h10);
		tick(n);
		rdc("pin down", ADDR_COUNT, 8'h0F);
	endtask
	task automatic t_event;
		wr(ADDR_EDGE, 8'h01);
		wr(ADDR_MODE, 8'h07);
		wr(ADDR_COUNT, 8'h00);
		repeat (3) begin
			eventInputPin <= 1'b1;
			repeat (8) @(posedge clk);
			eventInputPin <= 1'b0;
			repeat (8) @(posedge clk);
		end
		rdc("rising", ADDR_COUNT, 8'h03);
		wr(ADDR_EDGE, 8'h00);
		wr(ADDR_COUNT, 8'h00);
		eventInputPin <= 1'b1;
		repeat (8) @(posedge clk);
		rdc("no fall", ADDR_COUNT, 8'h00);
		eventInputPin <= 1'b0;
		repeat (8) @(posedge clk);
		rdc("fall", ADDR_COUNT, 8'h01);
	endtask

	// reset for 10 cycles, then scenarios in order
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		t_regs;
		t_taps;
		t_interval;
		t_reload;
		t_pin;
		t_event;
		finish_test;
	end
	// the run needs about 22k cycles; three times that means a hang
	initial begin
		#1500000;
		n_errors++;
		finish_test;
	end
endmodule // updown_reload_timer8_tb
